/* File: plfc_cfg.svh */
// constants for the loop feed-protected control block
`ifndef PLFC_CFG_SVH
`define PLFC_CFG_SVH
`define PLFC_ADDR_W 32
`define PLFC_OFS_CONTROL 32'he01fc080
`define PLFC_OFS_CONFIG 32'he01fc084
`define PLFC_OFS_STATUS 32'he01fc088
`define PLFC_OFS_FEED 32'he01fc08c
`define PLFC_CTL_ENABLE_POS 0
`define PLFC_CTL_CONNECT_POS 1
`define PLFC_CFG_MUL_LSB 0
`define PLFC_CFG_MUL_MSB 4
`define PLFC_CFG_DIV_LSB 5
`define PLFC_CFG_DIV_MSB 6
`define PLFC_STAT_ENABLE_POS 8
`define PLFC_STAT_CONNECT_POS 9
`define PLFC_STAT_LOCK_POS 10
`define PLFC_CONTROL_RESET 8'h00
`define PLFC_CONFIG_RESET 8'h00
`define PLFC_FEED_KEY_FIRST 8'haa
`define PLFC_FEED_KEY_SECOND 8'h55
`endif

/* File: plfc_pkg.sv */
// types for the loop feed-protected control block
package plfc_pkg;
    typedef enum logic [1:0] {
        PLFC_FEED_IDLE = 2'b01,
        PLFC_FEED_ARMED = 2'b10
    } plfc_feed_state_t;
endpackage

/* File: plfc_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/10ps
module plfc_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end
    assign dout = sync_q;
endmodule

/* File: plfc_pll_feed_protected_control.sv */
// feed-protected control, shadow state and clock select for the clock loop
//
// Contract
// [RULE_01] multiplier field selects loop factor one through thirty-two
// [RULE_02] divider field selects output division by 2, 4, 8 or 16
// [RULE_03] division of at least two keeps loop output at even duty
// [RULE_04] control and config holding contents need a feed to take effect
// [RULE_05] after reset the loop is off and bypassed
// [RULE_06] power-down forces the loop off and bypassed
// [RULE_07] loop is never enabled except by software write and valid feed
// [RULE_08] software programs, enables, waits for lock, then connects
// [RULE_09] holding writes are stored but do not change loop operation
// [RULE_10] status returns the settings in effect plus lock
// [RULE_11] feed register copies holding contents into shadow registers
// [RULE_12] fed enable lets loop try to lock with values in effect
// [RULE_13] fed connect runs the chip from the loop output
// [RULE_14] loop drives chip clock only when enable and connect shadows set
// [RULE_15] config holds multiplier in bits 4:0 and divider in bits 6:5
// [RULE_16] clock source switch is synchronised, glitch free
// [RULE_17] status bit ten reads lock
// [RULE_18] two key writes in a row make a feed; else sequence aborts
// [RULE_19] lock input is synchronised before it reaches status
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`include "plfc_cfg.svh"
module plfc_pll_feed_protected_control #(
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [`PLFC_ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic power_down,
    input wire logic lock_indicator,
    output logic loop_power_on,
    output logic [4:0] multiplier_field,
    output logic [1:0] divider_field,
    output logic [5:0] loop_multiply_factor,
    output logic [4:0] loop_divide_ratio,
    output logic core_clock_from_loop
);
    // status needs bits up to ten, so narrower buses cannot serve it
    if (DATA_W < 16) begin : g_bad_data_w
        $error("plfc: DATA_W must be at least 16");
    end

    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    logic sel_control;
    logic sel_config;
    logic sel_status;
    logic sel_feed;
    assign sel_control = (reg_addr == `PLFC_OFS_CONTROL);
    assign sel_config = (reg_addr == `PLFC_OFS_CONFIG);
    assign sel_status = (reg_addr == `PLFC_OFS_STATUS);
    assign sel_feed = (reg_addr == `PLFC_OFS_FEED);

    // holding registers, no effect on the loop yet
    logic [7:0] control_hold_q;
    logic [7:0] config_hold_q;
    // [RULE_09] store only, loop untouched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_hold_q <= `PLFC_CONTROL_RESET;
            config_hold_q <= `PLFC_CONFIG_RESET;
        end else if (reg_wr) begin
            if (sel_control) begin
                control_hold_q <= reg_wdata[7:0];
            end
            if (sel_config) begin
                config_hold_q <= reg_wdata[7:0];
            end
        end
    end

    // feed sequence tracker
    plfc_pkg::plfc_feed_state_t feed_state_q;
    logic feed_done;
    // [RULE_18] two consecutive keys, any other write aborts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            feed_state_q <= plfc_pkg::PLFC_FEED_IDLE;
        end else if (reg_wr) begin
            unique case (feed_state_q)
                plfc_pkg::PLFC_FEED_IDLE: begin
                    if (sel_feed && reg_wdata[7:0] == `PLFC_FEED_KEY_FIRST) begin
                        feed_state_q <= plfc_pkg::PLFC_FEED_ARMED;
                    end
                end
                plfc_pkg::PLFC_FEED_ARMED: begin
                    feed_state_q <= plfc_pkg::PLFC_FEED_IDLE;
                end
                default: begin
                    feed_state_q <= plfc_pkg::PLFC_FEED_IDLE;
                end
            endcase
        end
    end
    // [RULE_11] second key triggers the transfer
    assign feed_done = reg_wr && sel_feed && (feed_state_q == plfc_pkg::PLFC_FEED_ARMED)
        && (reg_wdata[7:0] == `PLFC_FEED_KEY_SECOND);

    // shadow registers that actually steer the loop
    logic enable_shadow_q;
    logic connect_shadow_q;
    logic [4:0] mul_shadow_q;
    logic [1:0] div_shadow_q;
    // [RULE_05] reset clears shadows
    // [RULE_06] power-down wins over feed
    // [RULE_07] only a valid feed can set enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_shadow_q <= 1'b0;
            connect_shadow_q <= 1'b0;
        end else if (power_down) begin
            enable_shadow_q <= 1'b0;
            connect_shadow_q <= 1'b0;
        end else if (feed_done) begin
            // [RULE_04] control needs feed
            enable_shadow_q <= control_hold_q[`PLFC_CTL_ENABLE_POS];
            connect_shadow_q <= control_hold_q[`PLFC_CTL_CONNECT_POS];
        end
    end
    // [RULE_15] config field positions
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mul_shadow_q <= 5'h00;
            div_shadow_q <= 2'h0;
        end else if (feed_done) begin
            // [RULE_04] config needs feed
            mul_shadow_q <= config_hold_q[`PLFC_CFG_MUL_MSB:`PLFC_CFG_MUL_LSB];
            div_shadow_q <= config_hold_q[`PLFC_CFG_DIV_MSB:`PLFC_CFG_DIV_LSB];
        end
    end

    // [RULE_12] enable powers the loop with values in effect
    assign loop_power_on = enable_shadow_q;
    assign multiplier_field = mul_shadow_q;
    assign divider_field = div_shadow_q;
    // [RULE_01] factor is field plus one
    assign loop_multiply_factor = {1'b0, mul_shadow_q} + 6'h01;
    // [RULE_02] ratio two to the power of field plus one
    // [RULE_03] ratio never below two, even duty
    assign loop_divide_ratio = 5'h02 << div_shadow_q;

    // lock arrives from analog loop, asynchronous
    logic lock_sync;
    // [RULE_19] synchronise lock
    plfc_sync2 u_lock_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(lock_indicator),
        .dout(lock_sync)
    );

    // select request, then handover in two steps so the mux never
    // switches to the loop on the same edge as the request; switch-off is not staged
    logic want_loop;
    logic sel_req_q;
    logic sel_q;
    // [RULE_14] both shadows must be one
    // [RULE_13] connect moves chip to loop clock
    assign want_loop = enable_shadow_q && connect_shadow_q;
    // [RULE_16] staged glitch-free switch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_req_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            sel_req_q <= want_loop;
            sel_q <= sel_req_q & want_loop;
        end
    end
    // no lock check here: software must wait for lock first
    // [RULE_08] relies on software order
    assign core_clock_from_loop = sel_q;

    // read data one cycle after strobe, zero otherwise
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    always_comb begin
        rdata_d = '0;
        if (sel_control) begin
            rdata_d[7:0] = control_hold_q;
        end else if (sel_config) begin
            rdata_d[7:0] = config_hold_q;
        end else if (sel_status) begin
            // [RULE_10] report values in effect
            rdata_d[`PLFC_CFG_MUL_MSB:`PLFC_CFG_MUL_LSB] = mul_shadow_q;
            rdata_d[`PLFC_CFG_DIV_MSB:`PLFC_CFG_DIV_LSB] = div_shadow_q;
            rdata_d[`PLFC_STAT_ENABLE_POS] = enable_shadow_q;
            rdata_d[`PLFC_STAT_CONNECT_POS] = connect_shadow_q;
            // [RULE_17] lock in bit ten
            rdata_d[`PLFC_STAT_LOCK_POS] = lock_sync;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end
    assign reg_rdata = rdata_q;
endmodule

/* File: plfc_chk.sv */
// assertions for the loop feed-protected control block
`timescale 1ns/10ps
`include "plfc_cfg.svh"
module plfc_chk #(
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [`PLFC_ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic power_down,
    input wire logic loop_power_on,
    input wire logic [4:0] multiplier_field,
    input wire logic [1:0] divider_field,
    input wire logic [5:0] loop_multiply_factor,
    input wire logic [4:0] loop_divide_ratio,
    input wire logic core_clock_from_loop
);
    logic fw;
    logic sr;
    assign fw = reg_wr && reg_addr == `PLFC_OFS_FEED;
    assign sr = reg_rd && reg_addr == `PLFC_OFS_STATUS;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_fac; loop_multiply_factor == {1'b0, multiplier_field} + 6'h01; endproperty
    a_fac: assert property (p_fac) else $error("factor wrong");
    property p_div; loop_divide_ratio == (5'h02 << divider_field); endproperty
    a_div: assert property (p_div) else $error("ratio wrong");
    property p_sel; core_clock_from_loop |-> $past(loop_power_on, 2); endproperty
    a_sel: assert property (p_sel) else $error("select without enable");
    property p_pd; power_down |=> !loop_power_on; endproperty
    a_pd: assert property (p_pd) else $error("enable survives power-down");
    property p_en; $rose(loop_power_on) |-> $past(fw && reg_wdata[7:0] == `PLFC_FEED_KEY_SECOND); endproperty
    a_en: assert property (p_en) else $error("enable without feed");
    property p_hold; !fw |=> $stable(multiplier_field) && $stable(divider_field); endproperty
    a_hold: assert property (p_hold) else $error("shadow moved without feed");
    // bit 7 reads zero
    property p_st; sr |=> reg_rdata[8:0] == {$past(loop_power_on), 1'b0, $past(divider_field), $past(multiplier_field)};
    endproperty
    a_st: assert property (p_st) else $error("status wrong");
    property p_idle; !reg_rd |=> reg_rdata == '0; endproperty
    a_idle: assert property (p_idle) else $error("read data not cleared");
    property p_rst; $rose(reset_n) |-> !loop_power_on && !core_clock_from_loop; endproperty
    a_rst: assert property (p_rst) else $error("loop active at reset");
    c_en: cover property ($rose(loop_power_on));
    c_con: cover property ($rose(core_clock_from_loop));
    c_pd: cover property (power_down && loop_power_on);
endmodule
bind plfc_pll_feed_protected_control plfc_chk #(.DATA_W(DATA_W)) u_chk (.*);

/* File: plfc_pll_feed_protected_control_tb_top.sv */
// testbench for the loop feed-protected control block
`timescale 1ns/10ps
`include "plfc_cfg.svh"
module plfc_pll_feed_protected_control_tb_top;
    logic clk, reset_n, reg_wr, reg_rd, power_down, lock_indicator, loop_power_on, core_clock_from_loop;
    logic [31:0] reg_addr, reg_wdata, reg_rdata;
    logic [4:0] multiplier_field, loop_divide_ratio;
    logic [1:0] divider_field;
    logic [5:0] loop_multiply_factor;
    int num_errors, n_compared;
    localparam logic [4:0] MT [4] = '{5'h00, 5'h1f, 5'h0a, 5'h01};
    localparam logic [5:0] FT [4] = '{6'h01, 6'h20, 6'h0b, 6'h02};
    localparam logic [4:0] RT [4] = '{5'h02, 5'h04, 5'h08, 5'h10};
    plfc_pll_feed_protected_control u_dut (.*);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    // strobe left high so writes can follow back to back
    task automatic wr(input logic [31:0] a, input logic [7:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= {24'h000000, v};
        @(posedge clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", e, reg_rdata);
    endtask
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic feed;
        wr(`PLFC_OFS_FEED, `PLFC_FEED_KEY_FIRST);
        wr(`PLFC_OFS_FEED, `PLFC_FEED_KEY_SECOND);
    endtask
    function automatic logic [19:0] ex(input logic c, input logic p, input logic [4:0] m, input logic [1:0] v);
        return {c, p, 5'h02 << v, {1'b0, m} + 6'h01, v, m};
    endfunction
    task automatic outs(input logic [19:0] e);
        chk("outs", {12'h000, e}, {12'h000, core_clock_from_loop, loop_power_on, loop_divide_ratio,
            loop_multiply_factor, divider_field, multiplier_field});
    endtask
    task automatic finish_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {reset_n, reg_wr, reg_rd, power_down} = 4'h0;
        {reg_addr, reg_wdata} = 64'h0;
        lock_indicator = 1'b1;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        idle(4);
        outs(ex(1'b0, 1'b0, 5'h00, 2'h0));
        wr(`PLFC_OFS_CONTROL, 8'h03);
        wr(`PLFC_OFS_CONFIG, 8'h7f);
        wr(`PLFC_OFS_STATUS, 8'hff);
        rd(`PLFC_OFS_CONTROL, 32'h03);
        rd(`PLFC_OFS_CONFIG, 32'h7f);
        rd(`PLFC_OFS_STATUS, 32'h400);
        // broken key pair must not load
        wr(`PLFC_OFS_FEED, `PLFC_FEED_KEY_FIRST);
        wr(`PLFC_OFS_CONFIG, 8'h25);
        wr(`PLFC_OFS_FEED, `PLFC_FEED_KEY_SECOND);
        idle(2);
        outs(ex(1'b0, 1'b0, 5'h00, 2'h0));
        wr(`PLFC_OFS_FEED, `PLFC_FEED_KEY_FIRST);
        rd(`PLFC_OFS_STATUS, 32'h400);
        wr(`PLFC_OFS_FEED, `PLFC_FEED_KEY_SECOND);
        rd(`PLFC_OFS_STATUS, 32'h725);
        idle(2);
        outs(ex(1'b1, 1'b1, 5'h05, 2'h1));
        for (int i = 0; i < 4; i++) begin
            wr(`PLFC_OFS_CONFIG, {1'b0, i[1:0], MT[i]});
            feed();
            idle(1);
            outs(ex(1'b1, 1'b1, MT[i], i[1:0]));
            chk("factor", {26'h0000000, FT[i]}, {26'h0000000, loop_multiply_factor});
            chk("ratio", {27'h0000000, RT[i]}, {27'h0000000, loop_divide_ratio});
        end
        wr(`PLFC_OFS_CONTROL, 8'h01);
        feed();
        idle(3);
        outs(ex(1'b0, 1'b1, 5'h01, 2'h3));
        wr(`PLFC_OFS_CONTROL, 8'h03);
        feed();
        power_down <= 1'b1;
        idle(5);
        outs(ex(1'b0, 1'b0, 5'h01, 2'h3));
        rd(`PLFC_OFS_STATUS, 32'h461);
        power_down <= 1'b0;
        idle(4);
        outs(ex(1'b0, 1'b0, 5'h01, 2'h3));
        lock_indicator <= 1'b0;
        idle(4);
        rd(`PLFC_OFS_STATUS, 32'h061);
        rd(32'he01fc090, 32'h0);
        rd(`PLFC_OFS_FEED, 32'h0);
        reset_n <= 1'b0;
        idle(2);
        outs(ex(1'b0, 1'b0, 5'h00, 2'h0));
        reset_n <= 1'b1;
        idle(4);
        rd(`PLFC_OFS_CONTROL, 32'h0);
        finish_test();
    end
endmodule
